// ---- hw/elc_pkg.sv ----
package elc_pkg;
   // Line layout.
   localparam int NUM_LINES = 19;
   localparam int NUM_PIN_LINES = 16;
   localparam int NUM_PORTS = 7;
   localparam int SEL_W = 4;
   localparam int SEL_BITS = NUM_PIN_LINES * SEL_W;
   localparam int SEL_PER_REG = 8;
   localparam int LINE_SUPPLY = 16;
   localparam int LINE_RTC = 17;
   localparam int LINE_USB = 18;

   // Register bus.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_EVT_EN = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RISE_EN = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_FALL_EN = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_SW_TRIG = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_PEND = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_SEL0 = 8'h1c;
   localparam logic [ADDR_W-1:0] OFF_SEL1 = 8'h20;

   // Reset values.
   localparam logic [NUM_LINES-1:0] RST_LINES = 19'h0;
   localparam logic [SEL_BITS-1:0] RST_SEL = 64'h0;
   localparam logic [DATA_W-1:0] RST_DATA = 32'h0;
endpackage : elc_pkg

// ---- hw/elc_edge_latch.sv ----
`timescale 1ns/100ps
module elc_edge_latch (
   // Line and reset.
   input wire logic i_src,
   input wire logic i_srst,
   // Edge selection from the register domain.
   input wire logic i_rise_en,
   input wire logic i_fall_en,
   // Edge toggles, one flip per captured edge.
   output logic o_rise_tog,
   output logic o_fall_tog
);
   // The line itself clocks these flops, so a pulse shorter than a bus clock
   // period, or one arriving while the bus clock is stopped, is still recorded.
   always_ff @(posedge i_src or posedge i_srst) begin
      if (i_srst) begin
         o_rise_tog <= 1'b0;
      end else if (i_rise_en) begin
         o_rise_tog <= ~o_rise_tog;
      end
   end

   always_ff @(negedge i_src or posedge i_srst) begin
      if (i_srst) begin
         o_fall_tog <= 1'b0;
      end else if (i_fall_en) begin
         o_fall_tog <= ~o_fall_tog;
      end
   end
endmodule : elc_edge_latch

// ---- hw/elc_src_sel.sv ----
`timescale 1ns/100ps
module elc_src_sel #(
   parameter int NLINE = 16,
   parameter int NPORT = 7,
   parameter int SEL_W = 4
) (
   // Pins, port-major: port p, bit g is i_pins[p*NLINE+g].
   input wire logic [NLINE*NPORT-1:0] i_pins,
   // One selector field per line.
   input wire logic [NLINE*SEL_W-1:0] i_sel,
   // Selected line levels.
   output logic [NLINE-1:0] o_line
);
   genvar g;
   generate
      for (g = 0; g < NLINE; g++) begin : g_line
         logic [SEL_W-1:0] s;
         assign s = i_sel[g*SEL_W +: SEL_W];
         // A selector value past the last port parks the line low.
         assign o_line[g] = (int'(s) < NPORT) ? i_pins[int'(s)*NLINE + g] : 1'b0;
      end
   endgenerate
endmodule : elc_src_sel

// ---- hw/elc_top.sv ----
`timescale 1ns/100ps
// How it works
// - Nineteen edge lines, each requests interrupt or event.
// - Per line rising, falling or both edges.
// - Per line mask, independent of others.
// - Pending bit per line records detected edge.
// - Edges caught even shorter than clock period.
// - Sixteen lines selected from 112 pins.
// - Unmasked selected edge wakes from stop.
// - Wake sources: pins, supply, alarm, USB.
// - Detection and wake work with clock stopped.
// - Keeps running in sleep, requests wake processor.
// - Supply line interrupts on fall, rise, both.
module elc_top (
   // Clock, reset, enable.
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   // Register port.
   input wire logic [elc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [elc_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [elc_pkg::DATA_W-1:0] o_rdata,
   // Line sources.
   input wire logic [elc_pkg::NUM_PIN_LINES*elc_pkg::NUM_PORTS-1:0] i_gpio,
   input wire logic i_supply_level_det,
   input wire logic i_rtc_alarm,
   input wire logic i_usb_wake,
   // Requests.
   output logic o_irq,
   output logic [elc_pkg::NUM_LINES-1:0] o_evt,
   output logic o_stop_wake
);
   localparam int N = elc_pkg::NUM_LINES;

   typedef struct packed {
      logic [N-1:0] irq_en;
      logic [N-1:0] evt_en;
      logic [N-1:0] rise_en;
      logic [N-1:0] fall_en;
      logic [N-1:0] pend;
      logic [elc_pkg::SEL_BITS-1:0] sel;
      logic [N-1:0] rs1;
      logic [N-1:0] rs2;
      logic [N-1:0] rs3;
      logic [N-1:0] fs1;
      logic [N-1:0] fs2;
      logic [N-1:0] fs3;
      logic [N-1:0] evt;
      logic irq;
      logic [elc_pkg::DATA_W-1:0] rdata;
   } elc_state_t;

   elc_state_t r;
   elc_state_t n;

   logic [elc_pkg::NUM_PIN_LINES-1:0] pin_line;
   logic [N-1:0] line;
   logic [N-1:0] rise_tog;
   logic [N-1:0] fall_tog;
   logic [N-1:0] hit;
   logic [N-1:0] sw_trig;
   logic [N-1:0] clr;
   logic [N-1:0] wake_mask;

   elc_src_sel #(
      .NLINE(elc_pkg::NUM_PIN_LINES),
      .NPORT(elc_pkg::NUM_PORTS),
      .SEL_W(elc_pkg::SEL_W)
   ) u_sel (
      .i_pins(i_gpio),
      .i_sel(r.sel),
      .o_line(pin_line)
   );

   // Lines above the pin group come from the on-chip wake sources.
   always_comb begin
      line = elc_pkg::RST_LINES;
      line[elc_pkg::NUM_PIN_LINES-1:0] = pin_line;
      line[elc_pkg::LINE_SUPPLY] = i_supply_level_det;
      line[elc_pkg::LINE_RTC] = i_rtc_alarm;
      line[elc_pkg::LINE_USB] = i_usb_wake;
   end

   // Reset also clears the capture flops, so an edge while reset is high is lost.
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_cap
         elc_edge_latch u_cap (
            .i_src(line[g]),
            .i_srst(i_srst),
            .i_rise_en(r.rise_en[g]),
            .i_fall_en(r.fall_en[g]),
            .o_rise_tog(rise_tog[g]),
            .o_fall_tog(fall_tog[g])
         );
      end
   endgenerate

   // Stop wake compares the edge toggles against the last values the clocked
   // side has taken in, so it rises without any clock and drops only after
   // the clock is back and the edge has been processed. It is combinational
   // and may glitch; the power controller must treat it as asynchronous.
   assign wake_mask = r.irq_en | r.evt_en;
   assign o_stop_wake = |(((rise_tog ^ r.rs3) | (fall_tog ^ r.fs3)) & wake_mask);

   // A software trigger acts as a hit in its own write cycle, so it obeys both masks.
   assign sw_trig = (i_wr && i_addr == elc_pkg::OFF_SW_TRIG) ? i_wdata[N-1:0] : elc_pkg::RST_LINES;
   assign clr = (i_wr && (i_addr == elc_pkg::OFF_PEND || i_addr == elc_pkg::OFF_CLEAR)) ?
                i_wdata[N-1:0] : elc_pkg::RST_LINES;
   assign hit = (r.rs2 ^ r.rs3) | (r.fs2 ^ r.fs3) | sw_trig;

   always_comb begin
      n = r;
      if (i_ce) begin
         n.rs1 = rise_tog;
         n.rs2 = r.rs1;
         n.rs3 = r.rs2;
         n.fs1 = fall_tog;
         n.fs2 = r.fs1;
         n.fs3 = r.fs2;
         // Event pulses bypass the pending bits entirely.
         n.evt = hit & r.evt_en;
         // An edge in the same cycle as a clear keeps its bit set.
         n.pend = (r.pend & ~clr) | (hit & r.irq_en);
         if (i_wr) begin
            case (i_addr)
               elc_pkg::OFF_IRQ_EN: n.irq_en = i_wdata[N-1:0];
               elc_pkg::OFF_EVT_EN: n.evt_en = i_wdata[N-1:0];
               elc_pkg::OFF_RISE_EN: n.rise_en = i_wdata[N-1:0];
               elc_pkg::OFF_FALL_EN: n.fall_en = i_wdata[N-1:0];
               elc_pkg::OFF_SEL0: n.sel[elc_pkg::DATA_W-1:0] = i_wdata;
               elc_pkg::OFF_SEL1: n.sel[elc_pkg::SEL_BITS-1:elc_pkg::DATA_W] = i_wdata;
               default: n.pend = n.pend;
            endcase
         end
         // The level request keeps running in sleep, so the processor wakes on it.
         n.irq = |(n.pend & n.irq_en);
         n.rdata = elc_pkg::RST_DATA;
         if (i_rd) begin
            case (i_addr)
               elc_pkg::OFF_IRQ_EN: n.rdata[N-1:0] = r.irq_en;
               elc_pkg::OFF_EVT_EN: n.rdata[N-1:0] = r.evt_en;
               elc_pkg::OFF_RISE_EN: n.rdata[N-1:0] = r.rise_en;
               elc_pkg::OFF_FALL_EN: n.rdata[N-1:0] = r.fall_en;
               elc_pkg::OFF_PEND: n.rdata[N-1:0] = r.pend;
               elc_pkg::OFF_SEL0: n.rdata = r.sel[elc_pkg::DATA_W-1:0];
               elc_pkg::OFF_SEL1: n.rdata = r.sel[elc_pkg::SEL_BITS-1:elc_pkg::DATA_W];
               default: n.rdata = elc_pkg::RST_DATA;
            endcase
         end
      end
   end

   // Reset leaves every line disabled and every selector on port zero.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign o_rdata = r.rdata;
   assign o_irq = r.irq;
   assign o_evt = r.evt;

   // All checks run on the bus clock and stay quiet while reset is held.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   AST_RDATA_IDLE: assert property (
      $past(i_ce) && !$past(i_rd) |-> o_rdata == elc_pkg::RST_DATA)
      else $error("read data not zero outside read answer");

   AST_PEND_READBACK: assert property (
      i_ce && i_rd && i_addr == elc_pkg::OFF_PEND |=> o_rdata[N-1:0] == $past(r.pend))
      else $error("pending read does not match state");

   AST_PEND_SET_WINS: assert property (
      i_ce && (hit & r.irq_en) != 0 |=> (r.pend & $past(hit & r.irq_en)) == $past(hit & r.irq_en))
      else $error("enabled edge did not set pending");

   AST_PEND_W1C: assert property (
      i_ce && i_wr && i_addr == elc_pkg::OFF_PEND && hit == 0
      |=> (r.pend & $past(i_wdata[N-1:0])) == 0)
      else $error("write one did not clear pending");

   AST_PEND_W0_KEEP: assert property (
      $past(i_ce) |-> ($past(r.pend) & ~$past(clr) & ~r.pend) == 0)
      else $error("pending bit lost without clear");

   AST_EVT_MASK: assert property (
      $past(i_ce) |-> (o_evt & ~$past(r.evt_en)) == 0)
      else $error("event from masked line");

   AST_EVT_NO_PEND: assert property (
      $past(i_ce) |-> (r.pend & ~$past(r.pend) & ~$past(r.irq_en)) == 0)
      else $error("pending set from interrupt-masked line");

   // A mask write in the same cycle may unmask a bit that is already pending.
   AST_IRQ_LEVEL: assert property (
      i_ce && (r.pend & r.irq_en) == 0 && hit == 0
      && !(i_wr && i_addr == elc_pkg::OFF_IRQ_EN) |=> !o_irq)
      else $error("interrupt high with no enabled pending bit");

   AST_SYNC_CATCHUP: assert property (
      (i_ce && $stable(rise_tog))[*4] |-> r.rs3 == rise_tog)
      else $error("captured edge not taken in after three cycles");

   AST_WAKE_ON_EDGE: assert property (
      (((r.rs2 ^ r.rs3) | (r.fs2 ^ r.fs3)) & wake_mask) != 0
      && r.rs2 == rise_tog && r.fs2 == fall_tog |-> o_stop_wake)
      else $error("unmasked edge without stop wake");

   AST_SEL_ROUTE: assert property (
      int'(r.sel[elc_pkg::SEL_W-1:0]) < elc_pkg::NUM_PORTS
      |-> pin_line[0] == i_gpio[int'(r.sel[elc_pkg::SEL_W-1:0])*elc_pkg::NUM_PIN_LINES])
      else $error("line zero not routed from selected pin");

   AST_FREEZE: assert property (
      !i_ce |=> r == $past(r))
      else $error("state moved with clock enable low");

   // Configuration writes land in the cycle after the strobe.
   AST_RISE_WRITE: assert property (
      i_ce && i_wr && i_addr == elc_pkg::OFF_RISE_EN |=> r.rise_en == $past(i_wdata[N-1:0]))
      else $error("rising edge selection not written");

   AST_FALL_WRITE: assert property (
      i_ce && i_wr && i_addr == elc_pkg::OFF_FALL_EN |=> r.fall_en == $past(i_wdata[N-1:0]))
      else $error("falling edge selection not written");

   AST_IRQ_EN_WRITE: assert property (
      i_ce && i_wr && i_addr == elc_pkg::OFF_IRQ_EN |=> r.irq_en == $past(i_wdata[N-1:0]))
      else $error("interrupt mask not written");

   AST_EVT_EN_WRITE: assert property (
      i_ce && i_wr && i_addr == elc_pkg::OFF_EVT_EN |=> r.evt_en == $past(i_wdata[N-1:0]))
      else $error("event mask not written");

   AST_SEL0_WRITE: assert property (
      i_ce && i_wr && i_addr == elc_pkg::OFF_SEL0
      |=> r.sel[elc_pkg::DATA_W-1:0] == $past(i_wdata))
      else $error("low selector word not written");

   AST_SEL1_WRITE: assert property (
      i_ce && i_wr && i_addr == elc_pkg::OFF_SEL1
      |=> r.sel[elc_pkg::SEL_BITS-1:elc_pkg::DATA_W] == $past(i_wdata))
      else $error("high selector word not written");

   // Write-only registers and the unused upper bits always read as zero.
   AST_WO_READS_ZERO: assert property (
      i_ce && i_rd && (i_addr == elc_pkg::OFF_CLEAR || i_addr == elc_pkg::OFF_SW_TRIG)
      |=> o_rdata == elc_pkg::RST_DATA)
      else $error("write-only register read back nonzero");

   AST_RDATA_HIGH_ZERO: assert property (
      i_ce && i_rd && i_addr == elc_pkg::OFF_PEND |=> o_rdata[elc_pkg::DATA_W-1:N] == '0)
      else $error("upper pending read bits not zero");

   AST_CLEAR_REG: assert property (
      i_ce && i_wr && i_addr == elc_pkg::OFF_CLEAR && hit == 0
      |=> (r.pend & $past(i_wdata[N-1:0])) == 0)
      else $error("clear register did not clear pending");

   AST_SWTRIG_PEND: assert property (
      i_ce && i_wr && i_addr == elc_pkg::OFF_SW_TRIG && (i_wdata[N-1:0] & r.irq_en) != 0
      |=> (r.pend & $past(i_wdata[N-1:0] & r.irq_en)) != 0)
      else $error("software trigger did not set pending");

   AST_IRQ_RAISE: assert property (
      i_ce && (hit & r.irq_en) != 0 && !(i_wr && i_addr == elc_pkg::OFF_IRQ_EN)
      |=> o_irq)
      else $error("enabled edge did not raise the interrupt");

   // An event pulse lasts one cycle unless a fresh hit follows it.
   AST_EVT_ONE_CYCLE: assert property (
      i_ce && hit == 0 |=> o_evt == elc_pkg::RST_LINES)
      else $error("event pulse held past one cycle");

   // A selector past the last port routes no pin at all.
   AST_SEL_PARK: assert property (
      int'(r.sel[elc_pkg::SEL_W-1:0]) >= elc_pkg::NUM_PORTS |-> !pin_line[0])
      else $error("parked line zero follows a pin");

   // Once the toggles have been still for the whole chain, the wake request must drop.
   AST_WAKE_RELEASE: assert property (
      (i_ce && $stable(rise_tog) && $stable(fall_tog))[*4] |-> !o_stop_wake)
      else $error("stop wake held after edges were taken in");

   CV_SUPPLY_PEND: cover property (
      $rose(r.pend[elc_pkg::LINE_SUPPLY]));
   CV_EVT: cover property (
      o_evt != 0);
   CV_IRQ: cover property (
      $rose(o_irq));
   CV_WAKE: cover property (
      $rose(o_stop_wake));
   CV_FREEZE_WAKE: cover property (
      !i_ce && o_stop_wake);
endmodule : elc_top

// ---- verification/elc_partner.sv ----
`timescale 1ns/100ps
module elc_partner (
   // Source levels seen by the lines.
   output logic [elc_pkg::NUM_PIN_LINES*elc_pkg::NUM_PORTS-1:0] o_gpio,
   output logic o_supply_level_det,
   output logic o_rtc_alarm,
   output logic o_usb_wake
);
   logic [114:0] src_r = 115'h0;
   assign o_gpio = src_r[111:0];
   assign o_supply_level_det = src_r[112];
   assign o_rtc_alarm = src_r[113];
   assign o_usb_wake = src_r[114];
   // Pins change with no regard to the bus clock, as real pins do. They move 5 ns after
   // the caller's edge, so configuration written at that edge has settled first.
   task automatic set_level(input int idx, input logic v);
      #5;
      src_r[idx] = v;
   endtask : set_level
   // A 10 ns pulse is far shorter than the 40 ns clock, so a sampled detector would lose it.
   task automatic glitch(input int idx);
      #5;
      src_r[idx] = ~src_r[idx];
      #10;
      src_r[idx] = ~src_r[idx];
   endtask : glitch
endmodule : elc_partner

// ---- verification/elc_tb_top.sv ----
`timescale 1ns/100ps
module elc_tb_top;
   logic i_clk = 1'b0;
   logic i_srst = 1'b0;
   logic i_ce = 1'b1;
   logic [7:0] i_addr = 8'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic [111:0] gpio;
   logic sup, rtc, usb, o_irq, o_stop_wake;
   logic [18:0] o_evt;
   logic [18:0] evt_seen = 19'h0;
   int evt_n = 0;
   int failures = 0;
   int checked = 0;
   logic [31:0] rv;

   elc_partner part_u (.o_gpio(gpio), .o_supply_level_det(sup), .o_rtc_alarm(rtc),
      .o_usb_wake(usb));
   elc_top dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_gpio(gpio),
      .i_supply_level_det(sup), .i_rtc_alarm(rtc), .i_usb_wake(usb), .o_irq(o_irq),
      .o_evt(o_evt), .o_stop_wake(o_stop_wake));

   initial begin
      forever #20 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      if (o_evt !== 19'h0) begin
         evt_seen <= evt_seen | o_evt;
         evt_n <= evt_n + 1;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask : rd

   task automatic pend(input logic [31:0] exp);
      repeat (8) @(posedge i_clk);
      rd(elc_pkg::OFF_PEND, rv);
      chk(rv, exp);
   endtask : pend

   task automatic close_out;
      $display("checks=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   task automatic t_reset;
      chk({o_irq, o_stop_wake}, 32'h0);
      rd(elc_pkg::OFF_PEND, rv);
      chk(rv, 32'h0);
      rd(8'h40, rv);
      chk(rv, 32'h0);
   endtask : t_reset

   task automatic t_short_pulse;
      wr(elc_pkg::OFF_IRQ_EN, 32'h1);
      wr(elc_pkg::OFF_RISE_EN, 32'h1);
      part_u.glitch(0);
      chk(o_stop_wake, 1'b1);
      pend(32'h1);
      chk({o_irq, o_stop_wake}, 32'h2);
      wr(elc_pkg::OFF_PEND, 32'h0);
      pend(32'h1);
      wr(elc_pkg::OFF_PEND, 32'h1);
      pend(32'h0);
      chk(o_irq, 1'b0);
   endtask : t_short_pulse

   task automatic t_select_both;
      wr(elc_pkg::OFF_SEL0, 32'h2000);
      wr(elc_pkg::OFF_IRQ_EN, 32'h8);
      wr(elc_pkg::OFF_RISE_EN, 32'h8);
      wr(elc_pkg::OFF_FALL_EN, 32'h8);
      part_u.set_level(3, 1'b1);
      pend(32'h0);
      part_u.set_level(35, 1'b1);
      pend(32'h8);
      wr(elc_pkg::OFF_PEND, 32'h8);
      part_u.set_level(35, 1'b0);
      pend(32'h8);
      wr(elc_pkg::OFF_PEND, 32'h8);
   endtask : t_select_both

   task automatic t_event_only;
      wr(elc_pkg::OFF_IRQ_EN, 32'h0);
      wr(elc_pkg::OFF_EVT_EN, 32'h8);
      evt_seen = 19'h0;
      evt_n = 0;
      part_u.set_level(35, 1'b1);
      pend(32'h0);
      chk({13'h0, evt_seen}, 32'h8);
      chk(evt_n, 1);
      chk(o_irq, 1'b0);
      wr(elc_pkg::OFF_EVT_EN, 32'h0);
   endtask : t_event_only

   task automatic t_wake_sources;
      for (int k = 16; k < 19; k++) begin
         wr(elc_pkg::OFF_IRQ_EN, 32'h1 << k);
         wr(elc_pkg::OFF_RISE_EN, 32'h0);
         wr(elc_pkg::OFF_FALL_EN, 32'h1 << k);
         part_u.set_level(96 + k, 1'b1);
         pend(32'h0);
         part_u.set_level(96 + k, 1'b0);
         pend(32'h1 << k);
         chk(o_irq, 1'b1);
         wr(elc_pkg::OFF_PEND, 32'h1 << k);
      end
   endtask : t_wake_sources

   // Edges arriving while the clock enable is low must be kept and handled later.
   task automatic t_freeze_trig;
      wr(elc_pkg::OFF_IRQ_EN, 32'h1);
      wr(elc_pkg::OFF_RISE_EN, 32'h1);
      i_ce <= 1'b0;
      part_u.glitch(0);
      wr(elc_pkg::OFF_IRQ_EN, 32'h0);
      repeat (4) @(posedge i_clk);
      chk({o_irq, o_stop_wake}, 32'h1);
      i_ce <= 1'b1;
      pend(32'h1);
      wr(elc_pkg::OFF_CLEAR, 32'h1);
      pend(32'h0);
      rd(elc_pkg::OFF_CLEAR, rv);
      chk(rv, 32'h0);
      wr(elc_pkg::OFF_SW_TRIG, 32'h1);
      pend(32'h1);
      chk(o_irq, 1'b1);
      wr(elc_pkg::OFF_CLEAR, 32'h1);
      wr(elc_pkg::OFF_SEL1, 32'h60);
      rd(elc_pkg::OFF_SEL1, rv);
      chk(rv, 32'h60);
      wr(elc_pkg::OFF_SEL0, 32'h2007);
      rd(elc_pkg::OFF_SEL0, rv);
      chk(rv, 32'h2007);
      part_u.glitch(0);
      pend(32'h0);
      chk(o_irq, 1'b0);
   endtask : t_freeze_trig

   initial begin
      #200000;
      failures++;
      close_out();
   end

   initial begin
      i_srst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_srst <= 1'b0;
      t_reset();
      t_short_pulse();
      t_select_both();
      t_event_only();
      t_wake_sources();
      t_freeze_trig();
      close_out();
   end
endmodule : elc_tb_top
